// ==== dv/bsrm_bank0_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsrm_props #(
  parameter REDUCED_PINS = 0
) (
  // clock and resets
  input wire CLK_I,
  input wire RST_N_I,
  input wire SOFT_RST_I,
  input wire CAUSE_TO_I,
  input wire CAUSE_PD_I,
  // bus side
  input wire [6:0] ADDR_I,
  input wire RD_I,
  input wire WR_I,
  input wire [7:0] WDATA_I,
  input wire HIT_O,
  input wire [7:0] RDATA_O,
  input wire IND_RD_O,
  // core state
  input wire PC_INC_I,
  input wire PC_JUMP_I,
  input wire [14:0] PC_O,
  input wire [4:0] STATUS_O,
  input wire [7:0] LATCH_D_O,
  input wire [3:0] LATCH_E_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  // ****************************************
  // latch then counter reload
  // ****************************************
  sequence s_latch_wr;
    WR_I && !SOFT_RST_I && ADDR_I == 7'h0A;
  endsequence
  sequence s_pclo_wr;
    WR_I && !SOFT_RST_I && ADDR_I == 7'h02;
  endsequence
  AST_PC_LOAD: assert property (s_latch_wr ##1 s_pclo_wr |=>
    PC_O == {$past(WDATA_I[6:0], 2), $past(WDATA_I)}) else $error("pc reload wrong");
  // no bus path other than the low byte may move the counter
  AST_PC_HOLD: assert property (!SOFT_RST_I && !PC_INC_I && !PC_JUMP_I &&
    !(WR_I && ADDR_I == 7'h02) |=> $stable(PC_O)) else $error("pc moved");
  AST_CORE_HIT: assert property (ADDR_I <= 7'h0B |-> HIT_O) else $error("core miss");
  AST_GAP_ZERO: assert property (RD_I && (ADDR_I == 7'h14 || ADDR_I == 7'h1D) |=>
    RDATA_O == 8'h00) else $error("gap read not zero");
  AST_CAUSE: assert property (SOFT_RST_I |=>
    STATUS_O[4:3] == {$past(CAUSE_TO_I), $past(CAUSE_PD_I)}) else $error("cause bits");
  AST_IND_RD: assert property (RD_I && ADDR_I[6:1] == 6'h00 |-> IND_RD_O)
    else $error("window read lost");
  AST_IND_ONLY: assert property (IND_RD_O |-> RD_I && ADDR_I[6:1] == 6'h00)
    else $error("stray window read");
  AST_REDUCED: assert property (RD_I && HIT_O && ADDR_I == 7'h10 |=>
    RDATA_O[7:4] == 4'h0 && (REDUCED_PINS == 0 ||
    (RDATA_O[2:0] == 3'h0 && LATCH_D_O == 8'h00 && LATCH_E_O[2:0] == 3'h0)))
    else $error("reduced pins driven");
endmodule
bind bsrm_bank0 bsrm_props #(.REDUCED_PINS(REDUCED_PINS)) bsrm_props_inst (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SOFT_RST_I(SOFT_RST_I), .CAUSE_TO_I(CAUSE_TO_I),
  .CAUSE_PD_I(CAUSE_PD_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .WR_I(WR_I), .WDATA_I(WDATA_I),
  .HIT_O(HIT_O), .RDATA_O(RDATA_O), .IND_RD_O(IND_RD_O), .PC_INC_I(PC_INC_I),
  .PC_JUMP_I(PC_JUMP_I), .PC_O(PC_O), .STATUS_O(STATUS_O), .LATCH_D_O(LATCH_D_O),
  .LATCH_E_O(LATCH_E_O));
`default_nettype wire

// ==== dv/bsrm_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bsrm_mem_model (
  // indirect path from the register bank
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:15];
  logic [7:0] last;
  initial last = 8'h00;
  // the window holds nothing, so all storage lives here
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i[3:0]] <= wdata_i;
    end
    if (rd_i) begin
      last <= mem[addr_i[3:0]];
    end
  end
  // released bus shows the inverse, never a stale value
  assign rdata_o = rd_i ? mem[addr_i[3:0]] : ~last;
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic CLK_I, RST_N_I, SOFT_RST_I, CAUSE_TO_I, CAUSE_PD_I, RD_I, WR_I;
  logic [6:0] ADDR_I;
  logic [7:0] WDATA_I, z, d, rv, acc;
  logic [2:0] fl;
  logic [14:0] pe;
  logic [15:0] s, ptr;
  wire HIT_O, IND_RD_O, IND_WR_O;
  wire [7:0] RDATA_O, IND_WDATA_O, IND_RDATA_I, WORK_O, INT_CTRL_O;
  wire [7:0] LATCH_A_O, LATCH_B_O, LATCH_C_O, LATCH_D_O;
  wire [15:0] IND_ADDR_O;
  wire [14:0] PC_O;
  wire [4:0] BANK_O, STATUS_O;
  wire [3:0] LATCH_E_O;
  int err_count, n_compared;
  bsrm_bank0 bsrm_bank0_inst (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SOFT_RST_I(SOFT_RST_I), .CAUSE_TO_I(CAUSE_TO_I),
    .CAUSE_PD_I(CAUSE_PD_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .WR_I(WR_I), .WDATA_I(WDATA_I),
    .HIT_O(HIT_O), .RDATA_O(RDATA_O), .IND_ADDR_O(IND_ADDR_O), .IND_RD_O(IND_RD_O),
    .IND_WR_O(IND_WR_O), .IND_WDATA_O(IND_WDATA_O), .IND_RDATA_I(IND_RDATA_I),
    .PC_INC_I(z[0]), .PC_JUMP_I(z[1]), .PC_JUMP_ADDR_I({z, z[2:0]}), .FLAGS_WE_I(z[2]),
    .FLAGS_I(z[2:0]), .PC_O(PC_O), .WORK_O(WORK_O), .BANK_O(BANK_O), .STATUS_O(STATUS_O),
    .INT_CTRL_O(INT_CTRL_O), .INT_SET_I(z[1:0]), .IOC_FLAG_I(z[3]), .PF1_SET_I(z),
    .PF2_SET_I(z), .PF3_SET_I(z), .GATE_VAL_I(z[4]), .CAP_OUT_I(z[5]), .PIN_A_I(z),
    .PIN_B_I(z), .PIN_C_I(z), .PIN_D_I(z), .PIN_E_I(z[3:0]), .LATCH_A_O(LATCH_A_O),
    .LATCH_B_O(LATCH_B_O), .LATCH_C_O(LATCH_C_O), .LATCH_D_O(LATCH_D_O),
    .LATCH_E_O(LATCH_E_O));
  bsrm_mem_model bsrm_mem_model_inst (.clk_i(CLK_I), .addr_i(IND_ADDR_O), .rd_i(IND_RD_O),
    .wr_i(IND_WR_O), .wdata_i(IND_WDATA_O), .rdata_o(IND_RDATA_I));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // six edges of core events; a jump takes latch bits 6:3 of 45h
  function automatic logic [14:0] pc_after(input logic [14:0] p, input logic [7:0] e);
    for (int i = 0; i < 6; i++)
      p = e[1] ? {4'h8, e, e[2:0]} : p + {14'h0000, e[0]};
    return p;
  endfunction
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge CLK_I);
    ADDR_I = a;
    WDATA_I = v;
    WR_I = 1'b1;
    @(negedge CLK_I);
    WR_I = 1'b0;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    @(negedge CLK_I);
    ADDR_I = a;
    RD_I = 1'b1;
    @(negedge CLK_I);
    RD_I = 1'b0;
    chk16({8'h00, RDATA_O}, {8'h00, e});
  endtask
  task automatic stop_test;
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************
  // clock, watchdog, sequence
  // ****************************************
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  initial begin
    #(50 * 5000);
    err_count++;
    stop_test;
  end
  initial begin
    {RST_N_I, SOFT_RST_I, CAUSE_TO_I, CAUSE_PD_I, RD_I, WR_I} = 6'h00;
    ADDR_I = 7'h00;
    WDATA_I = 8'h00;
    z = 8'h00;
    s = 16'h89E0;
    repeat (10) @(posedge CLK_I);
    @(negedge CLK_I);
    RST_N_I = 1'b1;
    rchk(7'h02, 8'h00);
    rchk(7'h03, 8'h18);
    rchk(7'h05, 8'h00);
    rchk(7'h1B, 8'hFF);
    wr(7'h14, 8'hFF);
    wr(7'h1D, 8'hFF);
    wr(7'h13, 8'hFF);
    rchk(7'h14, 8'h00);
    rchk(7'h1D, 8'h00);
    rchk(7'h13, 8'h7A);
    // latch then low byte on back-to-back edges
    @(negedge CLK_I);
    ADDR_I = 7'h0A;
    WDATA_I = 8'hC5;
    WR_I = 1'b1;
    @(negedge CLK_I);
    ADDR_I = 7'h02;
    WDATA_I = 8'h10;
    @(negedge CLK_I);
    WR_I = 1'b0;
    chk16({1'b0, PC_O}, 16'h4510);
    rchk(7'h0A, 8'h45);
    rchk(7'h02, 8'h10);
    for (int i = 0; i < 8; i++) begin
      s = lfsr(s);
      ptr = s;
      d = s[7:0] ^ 8'h3C;
      wr(7'h08, {3'h0, s[12:9], 1'b1});
      wr(7'h04, ptr[7:0]);
      wr(7'h05, ptr[15:8]);
      wr(7'h06, ptr[7:0] ^ 8'h01);
      wr(7'h07, ptr[15:8]);
      wr(7'h01, ~d);
      wr(7'h00, d);
      chk16(IND_ADDR_O, ptr);
      rchk(7'h00, d);
      rchk(7'h01, ~d);
      wr(7'h09, d);
      chk16({8'h00, WORK_O}, {8'h00, d});
      rchk(7'h09, d);
      rchk(7'h1B, 8'h00);
    end
    wr(7'h08, 8'hFF);
    rchk(7'h08, 8'h1F);
    chk16({11'h000, BANK_O}, 16'h001F);
    wr(7'h08, 8'h00);
    // random core events and pin levels; the counter is rebased before every burst
    acc = 8'h00;
    fl = 3'h0;
    wr(7'h13, 8'h00);
    for (int k = 0; k < 4; k++) begin
      s = lfsr(s);
      rv = s[7:0];
      acc = acc | rv;
      if (rv[2])
        fl = rv[2:0];
      wr(7'h02, 8'h10);
      pe = pc_after(15'h4510, rv);
      z = rv;
      repeat (6) @(negedge CLK_I);
      chk16({1'b0, PC_O}, {1'b0, pe});
      rchk(7'h0C, rv);
      rchk(7'h0F, rv);
      rchk(7'h10, {4'h0, rv[3:0]});
      rchk(7'h0B, {5'h00, acc[1:0], rv[3]});
      rchk(7'h03, {3'h0, 2'h3, fl});
      rchk(7'h11, acc);
      rchk(7'h12, acc & 8'hFD);
      rchk(7'h13, acc & 8'h7A);
      rchk(7'h19, {5'h00, rv[4], 2'h0});
      rchk(7'h1E, {6'h00, rv[5], 1'b0});
      chk16({8'h00, INT_CTRL_O}, {13'h0000, acc[1:0], 1'b0});
      for (int p = 0; p < 5; p++)
        wr(7'(12 + p), ~rv);
      chk16({LATCH_A_O, LATCH_B_O}, {~rv, ~rv});
      chk16({LATCH_C_O, LATCH_D_O}, {~rv, ~rv});
      chk16({12'h000, LATCH_E_O}, {12'h000, ~rv[3:0]});
      z = 8'h00;
    end
    wr(7'h1B, 8'h33);
    wr(7'h09, 8'hA5);
    @(negedge CLK_I);
    {SOFT_RST_I, CAUSE_TO_I, CAUSE_PD_I} = 3'b101;
    @(negedge CLK_I);
    SOFT_RST_I = 1'b0;
    chk16({14'h0, STATUS_O[4:3]}, 16'h0001);
    rchk(7'h09, 8'hA5);
    rchk(7'h0A, 8'h00);
    rchk(7'h1B, 8'hFF);
    rchk(7'h11, 8'h00);
    rchk(7'h02, 8'h00);
    chk16({8'h00, INT_CTRL_O}, 16'h0000);
    stop_test;
  end
endmodule
`default_nettype wire

// ==== verilog/bsrm_bank0.v ====
// Overview of operation
// - upper program counter byte has no read or write path; only the latch, jump address bits 10:8 and increment carries feed it.
// - seven-bit holding latch is copied into the upper counter byte on each reload.
// - core registers at offsets 00h to 0Bh decode in every bank.
// - unimplemented locations and bits, offsets 14h and 1Dh, read zero, ignore writes.
// - unknown bits uninitialised, unchanged bits kept on soft reset, conditional from cause.
// - reduced-pin build drops port D and port E bits 2..0, reading zero.
`timescale 1ns/1ps
`default_nettype none
`include "bsrm_regs.vh"

module bsrm_bank0 #(
  parameter REDUCED_PINS = 0
) (
  // clock and resets
  input wire CLK_I,
  input wire RST_N_I,
  input wire SOFT_RST_I,
  input wire CAUSE_TO_I,
  input wire CAUSE_PD_I,
  // core data memory access
  input wire [6:0] ADDR_I,
  input wire RD_I,
  input wire WR_I,
  input wire [7:0] WDATA_I,
  output wire HIT_O,
  output reg [7:0] RDATA_O,
  // indirect memory path
  output wire [15:0] IND_ADDR_O,
  output wire IND_RD_O,
  output wire IND_WR_O,
  output wire [7:0] IND_WDATA_O,
  input wire [7:0] IND_RDATA_I,
  // program counter and core state
  input wire PC_INC_I,
  input wire PC_JUMP_I,
  input wire [10:0] PC_JUMP_ADDR_I,
  input wire FLAGS_WE_I,
  input wire [2:0] FLAGS_I,
  output wire [14:0] PC_O,
  output wire [7:0] WORK_O,
  output wire [4:0] BANK_O,
  output wire [4:0] STATUS_O,
  output wire [7:0] INT_CTRL_O,
  // peripheral events
  input wire [1:0] INT_SET_I,
  input wire IOC_FLAG_I,
  input wire [7:0] PF1_SET_I,
  input wire [7:0] PF2_SET_I,
  input wire [7:0] PF3_SET_I,
  input wire GATE_VAL_I,
  input wire CAP_OUT_I,
  // port pins and latches
  input wire [7:0] PIN_A_I,
  input wire [7:0] PIN_B_I,
  input wire [7:0] PIN_C_I,
  input wire [7:0] PIN_D_I,
  input wire [3:0] PIN_E_I,
  output wire [7:0] LATCH_A_O,
  output wire [7:0] LATCH_B_O,
  output wire [7:0] LATCH_C_O,
  output wire [7:0] LATCH_D_O,
  output wire [3:0] LATCH_E_O
);

  // ****************************************
  // storage
  // ****************************************
  reg [7:0] pc_low;
  reg [6:0] pc_high;
  reg [6:0] pc_latch;
  reg [4:0] status;
  reg [7:0] ptr0_lo;
  reg [7:0] ptr0_hi;
  reg [7:0] ptr1_lo;
  reg [7:0] ptr1_hi;
  reg [4:0] bank;
  reg [7:0] work;
  reg [7:0] intctl;
  reg [7:0] pflag1;
  reg [7:0] pflag2;
  reg [7:0] pflag3;
  reg [7:0] t1_ctl;
  reg [7:0] t1_gate;
  reg [7:0] t2_cnt;
  reg [7:0] t2_per;
  reg [7:0] t2_ctl;
  reg [7:0] cap_ctl;
  reg [7:0] cap_ch;
  // power-up contents undefined, never reset
  reg [7:0] lat_a;
  reg [7:0] lat_b;
  reg [7:0] lat_c;
  reg [7:0] lat_d;
  reg [3:0] lat_e;
  reg [7:0] t0_cnt;
  reg [7:0] t1_lo;
  reg [7:0] t1_hi;
  // pin synchronisers
  reg [35:0] pin_s1;
  reg [35:0] pin_s2;
  reg [35:0] pin_s3;
  reg [35:0] pin_q;
  reg [7:0] next_rdata;

  // ****************************************
  // address decode
  // ****************************************
  wire core_sel = (ADDR_I <= `BSRM_OFS_INTCTL);
  wire bank0_sel = (bank == 5'h00) && (ADDR_I > `BSRM_OFS_INTCTL) &&
                   (ADDR_I <= `BSRM_OFS_CAP_CH);
  wire ind_sel = (ADDR_I == `BSRM_OFS_IND0) || (ADDR_I == `BSRM_OFS_IND1);
  wire wr = WR_I && HIT_O && !ind_sel;
  wire has_d = (REDUCED_PINS == 0);
  assign HIT_O = core_sel || bank0_sel;

  // window offsets store nothing; the access goes out at the pointer pair
  assign IND_ADDR_O = ADDR_I[0] ? {ptr1_hi, ptr1_lo} : {ptr0_hi, ptr0_lo};
  assign IND_RD_O = RD_I && ind_sel;
  assign IND_WR_O = WR_I && ind_sel;
  assign IND_WDATA_O = WDATA_I;

  assign PC_O = {pc_high, pc_low};
  assign WORK_O = work;
  assign BANK_O = bank;
  assign STATUS_O = status;
  assign INT_CTRL_O = intctl;
  assign LATCH_A_O = lat_a;
  assign LATCH_B_O = lat_b;
  assign LATCH_C_O = lat_c;
  assign LATCH_D_O = has_d ? lat_d : 8'h00;
  assign LATCH_E_O = has_d ? lat_e : {lat_e[3], 3'h0};

  function wr_at;
    input [6:0] ofs;
    begin
      wr_at = wr && (ADDR_I == ofs);
    end
  endfunction

  // ****************************************
  // program counter
  // ****************************************
  // the upper byte is never on the read mux or the write path
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pc_low <= 8'h00;
      pc_high <= 7'h00;
    end else if (SOFT_RST_I) begin
      pc_low <= 8'h00;
      pc_high <= 7'h00;
    end else if (wr_at(`BSRM_OFS_PCLO)) begin
      pc_low <= WDATA_I;
      pc_high <= pc_latch;
    end else if (PC_JUMP_I) begin
      {pc_high, pc_low} <= {pc_latch[6:3], PC_JUMP_ADDR_I};
    end else if (PC_INC_I) begin
      {pc_high, pc_low} <= PC_O + 15'h0001;
    end
  end

  // ****************************************
  // core and peripheral control registers
  // ****************************************
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pc_latch <= 7'h00;
      status <= `BSRM_RST_STATUS;
      ptr0_lo <= 8'h00;
      ptr0_hi <= 8'h00;
      ptr1_lo <= 8'h00;
      ptr1_hi <= 8'h00;
      bank <= 5'h00;
      work <= 8'h00;
      intctl <= 8'h00;
      pflag1 <= 8'h00;
      pflag2 <= 8'h00;
      pflag3 <= 8'h00;
      t1_ctl <= 8'h00;
      t1_gate <= 8'h00;
      t2_cnt <= 8'h00;
      t2_per <= `BSRM_RST_PR2;
      t2_ctl <= 8'h00;
      cap_ctl <= 8'h00;
      cap_ch <= 8'h00;
    end else if (SOFT_RST_I) begin
      // fields marked unchanged simply hold here
      pc_latch <= 7'h00;
      status[`BSRM_ST_TO] <= CAUSE_TO_I;
      status[`BSRM_ST_PD] <= CAUSE_PD_I;
      ptr0_hi <= 8'h00;
      ptr1_hi <= 8'h00;
      bank <= 5'h00;
      intctl[7:1] <= 7'h00;
      pflag1 <= 8'h00;
      pflag2 <= 8'h00;
      pflag3 <= 8'h00;
      t2_cnt <= 8'h00;
      t2_per <= `BSRM_RST_PR2;
      t2_ctl <= 8'h00;
      cap_ctl <= 8'h00;
      cap_ch <= 8'h00;
    end else begin
      if (wr_at(`BSRM_OFS_PCLATCH))
        pc_latch <= WDATA_I[6:0];
      if (FLAGS_WE_I)
        status[2:0] <= FLAGS_I;
      else if (wr_at(`BSRM_OFS_STATUS))
        status[2:0] <= WDATA_I[2:0];
      if (wr_at(`BSRM_OFS_PTR0_LO))
        ptr0_lo <= WDATA_I;
      if (wr_at(`BSRM_OFS_PTR0_HI))
        ptr0_hi <= WDATA_I;
      if (wr_at(`BSRM_OFS_PTR1_LO))
        ptr1_lo <= WDATA_I;
      if (wr_at(`BSRM_OFS_PTR1_HI))
        ptr1_hi <= WDATA_I;
      if (wr_at(`BSRM_OFS_BANK))
        bank <= WDATA_I[4:0];
      if (wr_at(`BSRM_OFS_WORK))
        work <= WDATA_I;
      // hardware set wins over a software clear in the same cycle
      intctl[7:1] <= (wr_at(`BSRM_OFS_INTCTL) ? WDATA_I[7:1] : intctl[7:1]) |
                     {5'h00, INT_SET_I};
      intctl[0] <= 1'b0;
      pflag1 <= (wr_at(`BSRM_OFS_PFLAG1) ? WDATA_I : pflag1) | PF1_SET_I;
      pflag2 <= ((wr_at(`BSRM_OFS_PFLAG2) ? WDATA_I : pflag2) | PF2_SET_I) &
                `BSRM_MSK_PFLAG2;
      pflag3 <= ((wr_at(`BSRM_OFS_PFLAG3) ? WDATA_I : pflag3) | PF3_SET_I) &
                `BSRM_MSK_PFLAG3;
      if (wr_at(`BSRM_OFS_T1_CTL))
        t1_ctl <= WDATA_I & `BSRM_MSK_T1_CTL;
      if (wr_at(`BSRM_OFS_T1_GATE))
        t1_gate <= WDATA_I & `BSRM_MSK_T1_GATE;
      if (wr_at(`BSRM_OFS_T2_CNT))
        t2_cnt <= WDATA_I;
      if (wr_at(`BSRM_OFS_T2_PER))
        t2_per <= WDATA_I;
      if (wr_at(`BSRM_OFS_T2_CTL))
        t2_ctl <= WDATA_I & `BSRM_MSK_T2_CTL;
      if (wr_at(`BSRM_OFS_CAP_CTL))
        cap_ctl <= WDATA_I & `BSRM_MSK_CAP_CTL;
      if (wr_at(`BSRM_OFS_CAP_CH))
        cap_ch <= WDATA_I & `BSRM_MSK_CAP_CH;
    end
  end

  // ****************************************
  // undefined-at-power-up registers
  // ****************************************
  // no reset term at all, so both resets leave them as they were
  always @(posedge CLK_I) begin
    if (wr_at(`BSRM_OFS_PORT_A))
      lat_a <= WDATA_I;
    if (wr_at(`BSRM_OFS_PORT_B))
      lat_b <= WDATA_I;
    if (wr_at(`BSRM_OFS_PORT_C))
      lat_c <= WDATA_I;
    if (wr_at(`BSRM_OFS_PORT_D))
      lat_d <= WDATA_I;
    if (wr_at(`BSRM_OFS_PORT_E))
      lat_e <= WDATA_I[3:0];
    if (wr_at(`BSRM_OFS_T0_CNT))
      t0_cnt <= WDATA_I;
    if (wr_at(`BSRM_OFS_T1_LO))
      t1_lo <= WDATA_I;
    if (wr_at(`BSRM_OFS_T1_HI))
      t1_hi <= WDATA_I;
  end

  // ****************************************
  // pin input synchronisers
  // ****************************************
  // a level is taken only once the second and third stages agree
  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pin_s1 <= 36'h000000000;
      pin_s2 <= 36'h000000000;
      pin_s3 <= 36'h000000000;
      pin_q <= 36'h000000000;
    end else begin
      pin_s1 <= {PIN_E_I, PIN_D_I, PIN_C_I, PIN_B_I, PIN_A_I};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q <= (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always @* begin
    next_rdata = 8'h00;
    case (ADDR_I)
      `BSRM_OFS_IND0, `BSRM_OFS_IND1: next_rdata = IND_RDATA_I;
      `BSRM_OFS_PCLO: next_rdata = pc_low;
      `BSRM_OFS_STATUS: next_rdata = {3'h0, status};
      `BSRM_OFS_PTR0_LO: next_rdata = ptr0_lo;
      `BSRM_OFS_PTR0_HI: next_rdata = ptr0_hi;
      `BSRM_OFS_PTR1_LO: next_rdata = ptr1_lo;
      `BSRM_OFS_PTR1_HI: next_rdata = ptr1_hi;
      `BSRM_OFS_BANK: next_rdata = {3'h0, bank};
      `BSRM_OFS_WORK: next_rdata = work;
      `BSRM_OFS_PCLATCH: next_rdata = {1'b0, pc_latch};
      `BSRM_OFS_INTCTL: next_rdata = {intctl[7:1], IOC_FLAG_I};
      `BSRM_OFS_PORT_A: next_rdata = pin_q[7:0];
      `BSRM_OFS_PORT_B: next_rdata = pin_q[15:8];
      `BSRM_OFS_PORT_C: next_rdata = pin_q[23:16];
      `BSRM_OFS_PORT_D: next_rdata = has_d ? pin_q[31:24] : 8'h00;
      `BSRM_OFS_PORT_E: next_rdata = {4'h0, pin_q[35], has_d ? pin_q[34:32] : 3'h0};
      `BSRM_OFS_PFLAG1: next_rdata = pflag1;
      `BSRM_OFS_PFLAG2: next_rdata = pflag2;
      `BSRM_OFS_PFLAG3: next_rdata = pflag3;
      `BSRM_OFS_T0_CNT: next_rdata = t0_cnt;
      `BSRM_OFS_T1_LO: next_rdata = t1_lo;
      `BSRM_OFS_T1_HI: next_rdata = t1_hi;
      `BSRM_OFS_T1_CTL: next_rdata = t1_ctl;
      `BSRM_OFS_T1_GATE: next_rdata = t1_gate | {5'h00, GATE_VAL_I, 2'h0};
      `BSRM_OFS_T2_CNT: next_rdata = t2_cnt;
      `BSRM_OFS_T2_PER: next_rdata = t2_per;
      `BSRM_OFS_T2_CTL: next_rdata = t2_ctl;
      `BSRM_OFS_CAP_CTL: next_rdata = cap_ctl | {6'h00, CAP_OUT_I, 1'b0};
      `BSRM_OFS_CAP_CH: next_rdata = cap_ch;
      default: next_rdata = 8'h00;
    endcase
    if (!HIT_O)
      next_rdata = 8'h00;
  end

  always @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      RDATA_O <= 8'h00;
    else if (RD_I)
      RDATA_O <= next_rdata;
  end

endmodule

`default_nettype wire

// ==== verilog/bsrm_regs.vh ====
`ifndef BSRM_REGS_VH
`define BSRM_REGS_VH

// ****************************************
// register offsets within a bank
// ****************************************
`define BSRM_OFS_IND0     7'h00
`define BSRM_OFS_IND1     7'h01
`define BSRM_OFS_PCLO     7'h02
`define BSRM_OFS_STATUS   7'h03
`define BSRM_OFS_PTR0_LO  7'h04
`define BSRM_OFS_PTR0_HI  7'h05
`define BSRM_OFS_PTR1_LO  7'h06
`define BSRM_OFS_PTR1_HI  7'h07
`define BSRM_OFS_BANK     7'h08
`define BSRM_OFS_WORK     7'h09
`define BSRM_OFS_PCLATCH  7'h0A
`define BSRM_OFS_INTCTL   7'h0B
`define BSRM_OFS_PORT_A   7'h0C
`define BSRM_OFS_PORT_B   7'h0D
`define BSRM_OFS_PORT_C   7'h0E
`define BSRM_OFS_PORT_D   7'h0F
`define BSRM_OFS_PORT_E   7'h10
`define BSRM_OFS_PFLAG1   7'h11
`define BSRM_OFS_PFLAG2   7'h12
`define BSRM_OFS_PFLAG3   7'h13
`define BSRM_OFS_GAP0     7'h14
`define BSRM_OFS_T0_CNT   7'h15
`define BSRM_OFS_T1_LO    7'h16
`define BSRM_OFS_T1_HI    7'h17
`define BSRM_OFS_T1_CTL   7'h18
`define BSRM_OFS_T1_GATE  7'h19
`define BSRM_OFS_T2_CNT   7'h1A
`define BSRM_OFS_T2_PER   7'h1B
`define BSRM_OFS_T2_CTL   7'h1C
`define BSRM_OFS_GAP1     7'h1D
`define BSRM_OFS_CAP_CTL  7'h1E
`define BSRM_OFS_CAP_CH   7'h1F

// ****************************************
// reset values and implemented-bit masks
// ****************************************
`define BSRM_RST_STATUS   5'h18
`define BSRM_RST_PR2      8'hFF
`define BSRM_RST_ZERO     8'h00
`define BSRM_MSK_PFLAG2   8'hFD
`define BSRM_MSK_PFLAG3   8'h7A
`define BSRM_MSK_T1_CTL   8'hFD
`define BSRM_MSK_T1_GATE  8'hFB
`define BSRM_MSK_T2_CTL   8'h7F
`define BSRM_MSK_CAP_CTL  8'hCD
`define BSRM_MSK_CAP_CH   8'h0F

// ****************************************
// field positions
// ****************************************
`define BSRM_ST_TO        4
`define BSRM_ST_PD        3
`define BSRM_IC_FLAGS_LO  1
`define BSRM_T1G_VAL      2
`define BSRM_CAP_OUT      1
`define BSRM_PC_JUMP_W    11

`endif
